/* File: hdl/pgm_mask_regs.sv */
// Local design decision: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module pgm_mask_regs
	import pgm_pkg::*;
#(
	parameter logic [7:0] OUT2_A_RESET = PGM_RST_MASK,
	parameter logic [7:0] OUT2_B_RESET = PGM_RST_MASK,
	parameter logic [7:0] OUT3_A_RESET = PGM_RST_MASK,
	parameter logic [7:0] OUT3_B_RESET = PGM_RST_MASK
)(
	// Clock and reset
	input  wire  logic        hclk,
	input  wire  logic        hresetn,
	// AHB-Lite slave
	input  wire  logic        hsel,
	input  wire  logic [31:0] haddr,
	input  wire  logic [1:0]  htrans,
	input  wire  logic        hwrite,
	input  wire  logic [2:0]  hsize,
	input  wire  logic        hready,
	input  wire  logic [31:0] hwdata,
	output logic [31:0]       hrdata,
	output logic              hreadyout,
	output logic              hresp,
	// Factory selection: 0 switch B2, 1 LDO A1
	input  wire  logic        shared_sel_ldo,
	// Power-good sources (high = good)
	input  wire  logic [5:0]  buck_rail_pg,
	input  wire  logic        switch_a_one_pg,
	input  wire  logic        ldo_a_two_pg,
	input  wire  logic        ldo_a_three_pg,
	input  wire  logic        switch_b_one_pg,
	input  wire  logic        switch_b_two_pg,
	input  wire  logic        ldo_a_one_pg,
	input  wire  logic        termination_regulator_pg,
	// Control input pins, order five, four, two, one
	input  wire  logic [3:0]  control_input_pins,
	// Power-good outputs
	output logic              pg_output_two,
	output logic              pg_output_three
);

	// *****************************************************************
	// Input synchronisation
	// *****************************************************************
	localparam int NSRC = 17;
	logic [NSRC-1:0] raw_src;
	logic [NSRC-1:0] src_s;
	logic            sel_raw_s;
	logic            sel_q;

	// Raw ordering follows mask layout, with b2 and a1 in place of the shared bit: {ctl(4), vtt, b2, a1, b1, a3, a2, sa1, bucks(6)}
	assign raw_src = {control_input_pins, termination_regulator_pg, switch_b_two_pg,
		ldo_a_one_pg, switch_b_one_pg, ldo_a_three_pg, ldo_a_two_pg, switch_a_one_pg,
		buck_rail_pg};

	pgm_sync #(.WIDTH(NSRC)) u_sync_src (
		.hclk     (hclk),
		.hresetn  (hresetn),
		.async_in (raw_src),
		.sync_out (src_s)
	);

	pgm_sync #(.WIDTH(1)) u_sync_sel (
		.hclk     (hclk),
		.hresetn  (hresetn),
		.async_in (shared_sel_ldo),
		.sync_out (sel_raw_s)
	);

	// Factory choice is latched once after reset release, never changes later
	logic sel_taken_q;
	logic [3:0] sel_wait_q;
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			sel_q       <= 1'b0;
			sel_taken_q <= 1'b0;
			sel_wait_q  <= 4'h0;
		end
		else if (!sel_taken_q)
		begin
			// Wait for the filter to settle before capturing the strap
			sel_wait_q <= sel_wait_q + 4'h1;
			if (sel_wait_q == 4'h5)
			begin
				sel_q       <= sel_raw_s;
				sel_taken_q <= 1'b1;
			end
		end
	end

	// *****************************************************************
	// Mask registers
	// *****************************************************************
	logic [7:0] out2_pg_mask_a_q;
	logic [7:0] out2_pg_mask_b_q;
	logic [7:0] out3_pg_mask_a_q;
	logic [7:0] out3_pg_mask_b_q;

	logic [9:0] wr_addr_q;
	pgm_bus_e   bus_st_q;

	// Address phase is accepted when selected, ready and a transfer is active
	logic addr_ok;
	assign addr_ok = hsel && hready && htrans[1];

	// Write pipeline: capture address phase, commit in data phase
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_addr_q <= 10'h000;
			bus_st_q  <= PGM_ST_IDLE;
		end
		else
		begin
			bus_st_q  <= (addr_ok && hwrite) ? PGM_ST_WRITE : PGM_ST_IDLE;
			if (addr_ok)
				wr_addr_q <= haddr[9:0];
		end
	end

	// Register writes; bytes above bit 7 are dropped
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			out2_pg_mask_a_q <= OUT2_A_RESET;
			out2_pg_mask_b_q <= OUT2_B_RESET;
			out3_pg_mask_a_q <= OUT3_A_RESET;
			out3_pg_mask_b_q <= OUT3_B_RESET;
		end
		else if (bus_st_q == PGM_ST_WRITE)
		begin
			unique case (wr_addr_q)
				pgm_addr(PGM_IDX_OUT2_MASK_A): out2_pg_mask_a_q <= hwdata[7:0];
				pgm_addr(PGM_IDX_OUT2_MASK_B): out2_pg_mask_b_q <= hwdata[7:0];
				pgm_addr(PGM_IDX_OUT3_MASK_A): out3_pg_mask_a_q <= hwdata[7:0];
				pgm_addr(PGM_IDX_OUT3_MASK_B): out3_pg_mask_b_q <= hwdata[7:0];
				default: ;
			endcase
		end
	end

	// Read data registered at address phase; zero for unmapped words
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata <= 32'h0000_0000;
		else if (addr_ok && !hwrite)
		begin
			hrdata <= 32'h0000_0000;
			if (haddr[9:0] == pgm_addr(PGM_IDX_OUT2_MASK_A))
				hrdata[7:0] <= out2_pg_mask_a_q;
			else if (haddr[9:0] == pgm_addr(PGM_IDX_OUT2_MASK_B))
				hrdata[7:0] <= out2_pg_mask_b_q;
			else if (haddr[9:0] == pgm_addr(PGM_IDX_OUT3_MASK_A))
				hrdata[7:0] <= out3_pg_mask_a_q;
			else if (haddr[9:0] == pgm_addr(PGM_IDX_OUT3_MASK_B))
				hrdata[7:0] <= out3_pg_mask_b_q;
			else if (haddr[9:0] == pgm_addr(PGM_IDX_STATUS))
			begin
				hrdata[PGM_POS_STS_OUT2] <= pg_output_two;
				hrdata[PGM_POS_STS_OUT3] <= pg_output_three;
				hrdata[PGM_POS_STS_SEL]  <= sel_q;
			end
			// A write still in its data phase lands this edge: forward it so a
			// pipelined read of the same mask does not return the stale byte
			if (bus_st_q == PGM_ST_WRITE && wr_addr_q == haddr[9:0]
				&& (wr_addr_q >> 4) == (pgm_addr(PGM_IDX_OUT2_MASK_A) >> 4))
				hrdata[7:0] <= hwdata[7:0];
		end
	end

	// Zero wait states, always OKAY
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
		else
		begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// *****************************************************************
	// Power-good trees
	// *****************************************************************
	logic [7:0]  shared_good;
	logic [15:0] out2_good;
	logic [15:0] out3_good;
	logic [15:0] out2_mask;
	logic [15:0] out3_mask;
	logic        tree2;
	logic        tree3;
	logic        shared_pg;

	// Shared-rail bit follows the factory choice
	assign shared_pg = sel_q ? src_s[10] : src_s[11];
	// Mask-B source byte: control_input_five,control_input_four,control_input_two,control_input_one,vtt,shared,b1,a3
	assign shared_good = {src_s[16:12], shared_pg, src_s[9], src_s[8]};
	assign out2_good = {shared_good, src_s[7:0]};
	assign out3_good = {shared_good, src_s[7:0]};
	assign out2_mask = {out2_pg_mask_b_q, out2_pg_mask_a_q};
	assign out3_mask = {out3_pg_mask_b_q, out3_pg_mask_a_q};

	pgm_tree #(.WIDTH(16)) u_tree2 (
		.good_in  (out2_good),
		.mask_in  (out2_mask),
		.good_out (tree2)
	);

	pgm_tree #(.WIDTH(16)) u_tree3 (
		.good_in  (out3_good),
		.mask_in  (out3_mask),
		.good_out (tree3)
	);

	// Registered outputs; held low until the strap is captured
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pg_output_two   <= 1'b0;
			pg_output_three <= 1'b0;
		end
		else
		begin
			pg_output_two   <= tree2 && sel_taken_q;
			pg_output_three <= tree3 && sel_taken_q;
		end
	end

endmodule : pgm_mask_regs
`default_nettype wire

/* File: hdl/pgm_pkg.sv */
package pgm_pkg;

	// *****************************************************************
	// Register map (printed offsets not multiples of four: word index)
	// *****************************************************************
	localparam logic [7:0] PGM_IDX_OUT2_MASK_B = 8'ha9;
	localparam logic [7:0] PGM_IDX_OUT3_MASK_A = 8'haa;
	localparam logic [7:0] PGM_IDX_OUT3_MASK_B = 8'hab;
	localparam logic [7:0] PGM_IDX_OUT2_MASK_A = 8'ha8;
	localparam logic [7:0] PGM_IDX_STATUS      = 8'hb0;

	// *****************************************************************
	// Field positions
	// *****************************************************************
	localparam int PGM_POS_CTL_LO   = 4;
	localparam int PGM_POS_SHARED   = 2;
	localparam int PGM_POS_STS_OUT2 = 0;
	localparam int PGM_POS_STS_OUT3 = 1;
	localparam int PGM_POS_STS_SEL  = 2;

	// *****************************************************************
	// Reset values (factory dependent; defaults are plain)
	// *****************************************************************
	localparam logic [7:0] PGM_RST_MASK = 8'h00;

	// Input synchroniser depth
	localparam int PGM_SYNC_STAGES = 3;

	// Bus states
	typedef enum logic [1:0] {
		PGM_ST_IDLE  = 2'b01,
		PGM_ST_WRITE = 2'b10
	} pgm_bus_e;

	// Byte address of a register index
	function automatic logic [9:0] pgm_addr(input logic [7:0] idx);
		pgm_addr = {idx, 2'b00};
	endfunction : pgm_addr

endpackage : pgm_pkg

/* File: hdl/pgm_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module pgm_sync
	import pgm_pkg::*;
#(
	parameter int WIDTH = 1
)(
	// Clock and reset
	input  wire  logic             hclk,
	input  wire  logic             hresetn,
	// Asynchronous inputs and filtered result
	input  wire  logic [WIDTH-1:0] async_in,
	output var   logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage1_q;
	logic [WIDTH-1:0] stage2_q;
	logic [WIDTH-1:0] stage3_q;

	// Three-flop chain; first stage feeds only the second
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			stage1_q <= '0;
			stage2_q <= '0;
			stage3_q <= '0;
		end
		else
		begin
			stage1_q <= async_in;
			stage2_q <= stage1_q;
			stage3_q <= stage2_q;
		end
	end

	// A change counts only once stages two and three agree
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			sync_out <= '0;
		else
			for (int i = 0; i < WIDTH; i++)
				if (stage2_q[i] == stage3_q[i])
					sync_out[i] <= stage2_q[i];
	end

endmodule : pgm_sync
`default_nettype wire

/* File: hdl/pgm_tree.sv */
`timescale 1ns/1ps
`default_nettype none
module pgm_tree
	import pgm_pkg::*;
#(
	parameter int WIDTH = 16
)(
	// Sources and masks (1 = ignore)
	input  wire  logic [WIDTH-1:0] good_in,
	input  wire  logic [WIDTH-1:0] mask_in,
	// Combined power good
	output logic                   good_out
);

	// Masked sources force one so they cannot pull the tree low
	assign good_out = &(good_in | mask_in);

endmodule : pgm_tree
`default_nettype wire

/* File: testbench/pgm_mask_regs_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module pgm_mask_regs_asserts
	import pgm_pkg::*;
(
	// Bus
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic [31:0] hwdata,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	// Sources and outputs
	input wire logic        shared_sel_ldo,
	input wire logic [5:0]  buck_rail_pg,
	input wire logic        switch_a_one_pg,
	input wire logic        ldo_a_two_pg,
	input wire logic        ldo_a_three_pg,
	input wire logic        switch_b_one_pg,
	input wire logic        switch_b_two_pg,
	input wire logic        ldo_a_one_pg,
	input wire logic        termination_regulator_pg,
	input wire logic [3:0]  control_input_pins,
	input wire logic        pg_output_two,
	input wire logic        pg_output_three
);
	// ************************************************
	// Shadow masks and settle counter
	// ************************************************
	logic [7:0]  m_q [4];
	logic [15:0] src;
	logic [15:0] bad2;
	logic [15:0] bad3;
	logic [31:0] prev_q;
	logic [1:0]  ix_q;
	logic [4:0]  cnt_q;
	logic        hit;
	logic        wr_q;
	logic        rd_q;
	logic        ok;
	// Strap is only changed under reset, so the live pin is safe here
	assign src = {control_input_pins, termination_regulator_pg,
		shared_sel_ldo ? ldo_a_one_pg : switch_b_two_pg, switch_b_one_pg,
		ldo_a_three_pg, ldo_a_two_pg, switch_a_one_pg, buck_rail_pg};
	assign bad2 = ~src & ~{m_q[1], m_q[0]};
	assign bad3 = ~src & ~{m_q[3], m_q[2]};
	assign hit  = hsel && hready && htrans[1] && haddr[9:4] == 6'h2a;
	// Settled, and nothing changed since the last edge (design lags a change)
	assign ok   = cnt_q == 5'h10 && {bad2, bad3} == prev_q;
	// Pins cross a synchroniser, so outputs are judged only once settled
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			m_q    <= '{default: 8'h00};
			wr_q   <= 1'b0;
			rd_q   <= 1'b0;
			ix_q   <= 2'b00;
			prev_q <= 32'h0000_0000;
			cnt_q  <= 5'h00;
		end
		else
		begin
			wr_q   <= hit && hwrite;
			rd_q   <= hit && !hwrite;
			ix_q   <= haddr[3:2];
			prev_q <= {bad2, bad3};
			cnt_q  <= ({bad2, bad3} != prev_q) ? 5'h00 : cnt_q + 5'(!ok);
			if (wr_q)
				m_q[ix_q] <= hwdata[7:0];
		end
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus wait or error seen");
	a_read_back: assert property (rd_q |-> hrdata == {24'h00_0000, m_q[ix_q]})
		else $error("mask readback wrong");
	a_ctl_two: assert property (ok && |bad2[15:12] |-> !pg_output_two)
		else $error("output two good with a pin low");
	a_rail_two: assert property (ok && |bad2[11:8] |-> !pg_output_two)
		else $error("output two good with a rail bad");
	a_shared_pick: assert property (ok && bad2 == 16'h0400 |-> !pg_output_two)
		else $error("shared bit watched the wrong rail");
	a_rails_three: assert property (ok && |bad3[7:0] |-> !pg_output_three)
		else $error("output three good with a rail bad");
	a_ctl_three: assert property (ok && |bad3[15:12] |-> !pg_output_three)
		else $error("output three good with a pin low");
	a_rail_three: assert property (ok && |bad3[11:8] |-> !pg_output_three)
		else $error("output three good with a source bad");
	a_all_good: assert property (ok |-> pg_output_two == !(|bad2)
		&& pg_output_three == !(|bad3))
		else $error("an output disagrees with its tree");
endmodule : pgm_mask_regs_asserts
bind pgm_mask_regs pgm_mask_regs_asserts u_chk (.*);
`default_nettype wire

/* File: testbench/pgm_pg_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module pgm_pg_monitor
(
	// Clock, reset and watched pins
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic [1:0] pg_in,
	// Pins as the system sees them
	output var  logic [1:0] pg_seen
);
	// ************************************************
	// System side synchroniser
	// ************************************************
	logic [1:0] meta_q;
	// Two flops: the system does not share the device's clock in general
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			meta_q  <= 2'b00;
			pg_seen <= 2'b00;
		end
		else
		begin
			meta_q  <= pg_in;
			pg_seen <= meta_q;
		end
	end
endmodule : pgm_pg_monitor
`default_nettype wire

/* File: testbench/tb_power_good_tree_mask.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_power_good_tree_mask
	import pgm_pkg::*;
;
	// ************************************************
	// Stimulus, bus tasks and sequence
	// ************************************************
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic        strap = 1'b0;
	logic [1:0]  htrans = 2'b00;
	logic [31:0] haddr = 32'h0000_0000;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [15:0] src = 16'hffff;
	logic [31:0] hrdata;
	logic [31:0] rd;
	logic [1:0]  pg;
	logic [1:0]  seen;
	logic        hreadyout;
	int          miscompares = 0;
	int          n_compared = 0;
	always #2.5 hclk = ~hclk;
	// Shared bit 10 drives the selected rail; the other gets the inverse
	pgm_mask_regs dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hready(hreadyout),
		.hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(),
		.shared_sel_ldo(strap), .buck_rail_pg(src[5:0]), .switch_a_one_pg(src[6]),
		.ldo_a_two_pg(src[7]), .ldo_a_three_pg(src[8]), .switch_b_one_pg(src[9]),
		.switch_b_two_pg(src[10] ^ strap), .ldo_a_one_pg(src[10] ^ ~strap),
		.termination_regulator_pg(src[11]), .control_input_pins(src[15:12]),
		.pg_output_two(pg[1]), .pg_output_three(pg[0]));
	pgm_pg_monitor u_sys (.hclk(hclk), .hresetn(hresetn), .pg_in(pg), .pg_seen(seen));
	function automatic logic [31:0] ba(input logic [7:0] i);
		ba = {22'h00_0000, i, 2'b00};
	endfunction : ba
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			miscompares++;
			$display("mismatch at %0t: saw %h, expected %h", $time, got, exp);
		end
	endtask : check
	task automatic bus(input logic w, input logic [7:0] i, input logic [31:0] d);
		haddr  <= ba(i);
		hwrite <= w;
		htrans <= 2'b10;
		hsel   <= 1'b1;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hsel   <= 1'b0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : bus
	task automatic settle(input logic [1:0] exp);
		repeat (24) @(posedge hclk);
		check({30'h0, seen}, {30'h0, exp});
	endtask : settle
	task automatic complete_run;
		$display("compared %0d, miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : complete_run
	initial
	begin
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		// Reset value, readback of the low byte, then clear; 0xac and 0xad are unmapped
		for (int i = 0; i < 6; i++)
		begin
			bus(1'b0, 8'(PGM_IDX_OUT2_MASK_A + i), 32'h0);
			check(rd, 32'h0);
			bus(1'b1, 8'(PGM_IDX_OUT2_MASK_A + i), 32'hffff_ff5a ^ i);
			bus(1'b0, 8'(PGM_IDX_OUT2_MASK_A + i), 32'h0);
			check(rd, (i < 4) ? 32'(8'h5a ^ i) : 32'h0);
			bus(1'b1, 8'(PGM_IDX_OUT2_MASK_A + i), 32'h0);
		end
		settle(2'b11);
		// Status word: both outputs good, switch B2 strap
		bus(1'b0, PGM_IDX_STATUS, 32'h0);
		check(rd, 32'h0000_0003);
		// Each source: fails both trees, then masked per tree
		for (int b = 0; b < 16; b++)
		begin
			src <= ~(16'h0001 << b);
			settle(2'b00);
			bus(1'b1, 8'(PGM_IDX_OUT2_MASK_A + b / 8), 32'(1 << (b % 8)));
			settle(2'b10);
			bus(1'b1, 8'(PGM_IDX_OUT3_MASK_A + b / 8), 32'(1 << (b % 8)));
			settle(2'b11);
			bus(1'b1, 8'(PGM_IDX_OUT2_MASK_A + b / 8), 32'h0);
			bus(1'b1, 8'(PGM_IDX_OUT3_MASK_A + b / 8), 32'h0);
		end
		// Second reset with the other strap: shared bit now follows LDO A1
		hresetn <= 1'b0;
		strap   <= 1'b1;
		src     <= 16'hfbff;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		settle(2'b00);
		src <= 16'hffff;
		settle(2'b11);
		bus(1'b0, PGM_IDX_STATUS, 32'h0);
		check(rd, 32'h0000_0007);
		complete_run();
	end
	// Watchdog well past the expected run of about seven microseconds
	initial
	begin
		#100us;
		miscompares++;
		complete_run();
	end
endmodule : tb_power_good_tree_mask
`default_nettype wire
